// >>> core/sbl_pkg.sv
// Operation
// RULE_01: First byte 5AH at 9600 bps is echoed; unrecognised bytes get no answer.
// RULE_02: Baud change code is echoed; on error three A1H, A3H or 62H, then halt.
// RULE_03: From byte five the new rate applies; command 60H is echoed.
// RULE_04: Invalid command byte: send 63H three times, then halt.
// RULE_05: Count storage address bytes seven and nine get no answer.
// RULE_06: Comparison start address bytes eleven and thirteen get no answer.
// RULE_07: Controller sends password string from byte fifteen; device stays silent.
// RULE_08: All FFH in FFE0H to FFFFH means blank; password comparison skipped.
// RULE_09: Password mismatch stops the link and halts until pin reset.
// RULE_10: Any error during password address or string reception halts silently.
// RULE_11: With read protection enabled the device halts instead of loading.
// RULE_12: Controller must not send a lone end record after the password.
// RULE_13: During loading nothing is echoed; bytes before 3AH are discarded.
// RULE_14: Record is length, address, type, data, checksum; data goes to RAM.
// RULE_15: Receive error or malformed record halts without any error code.
// RULE_16: After a clean end record send checksum upper byte, then lower.
// RULE_17: Controller waits for both checksum bytes to judge the transfer.
// RULE_18: After both checksum bytes execution starts at first data record address.
// RULE_19: Controller always sends a baud code; 28H keeps 9600 bps.
// RULE_20: Password length N read from count address; N bytes compared from start.
// RULE_21: Once halted, all input is ignored and nothing is sent until reset.
package sbl_pkg;

   localparam logic [7:0]  SBL_MATCH      = 8'h5A;
   localparam logic [7:0]  SBL_BAUD_9600  = 8'h28;
   localparam logic [7:0]  SBL_CMD_RAM    = 8'h60;
   localparam logic [7:0]  SBL_ERR_FRAME  = 8'hA1;
   localparam logic [7:0]  SBL_ERR_OVRN   = 8'hA3;
   localparam logic [7:0]  SBL_ERR_BAUD   = 8'h62;
   localparam logic [7:0]  SBL_ERR_CMD    = 8'h63;
   localparam logic [7:0]  SBL_REC_START  = 8'h3A;
   localparam logic [7:0]  SBL_REC_DATA   = 8'h00;
   localparam logic [7:0]  SBL_REC_END    = 8'h01;
   localparam logic [7:0]  SBL_BLANK_BYTE = 8'hFF;
   localparam logic [15:0] SBL_BLANK_LO   = 16'hFFE0;
   localparam logic [15:0] SBL_BLANK_HI   = 16'hFFFF;
   localparam logic [1:0]  SBL_ERR_REPEAT = 2'h3;
   localparam logic [7:0]  SBL_ONE8       = 8'h01;
   localparam logic [1:0]  SBL_ONE2       = 2'h1;

   typedef enum logic [4:0] {
      SBL_S_MATCH     = 5'h00,
      SBL_S_ECHO1     = 5'h01,
      SBL_S_BAUD      = 5'h03,
      SBL_S_ECHO2     = 5'h02,
      SBL_S_CMD       = 5'h06,
      SBL_S_ECHO3     = 5'h07,
      SBL_S_PCA_H     = 5'h05,
      SBL_S_PCA_L     = 5'h04,
      SBL_S_PSA_H     = 5'h0C,
      SBL_S_PSA_L     = 5'h0D,
      SBL_S_BLANK_RD  = 5'h0F,
      SBL_S_BLANK_CHK = 5'h0E,
      SBL_S_CNT_RD    = 5'h0A,
      SBL_S_CNT_CHK   = 5'h0B,
      SBL_S_PW_RX     = 5'h09,
      SBL_S_PW_CHK    = 5'h08,
      SBL_S_HEX_IDLE  = 5'h18,
      SBL_S_HEX_LEN   = 5'h19,
      SBL_S_HEX_AH    = 5'h1B,
      SBL_S_HEX_AL    = 5'h1A,
      SBL_S_HEX_TYPE  = 5'h1E,
      SBL_S_HEX_DATA  = 5'h1F,
      SBL_S_HEX_CK    = 5'h1D,
      SBL_S_SUM_H     = 5'h1C,
      SBL_S_SUM_L     = 5'h14,
      SBL_S_RUN       = 5'h15,
      SBL_S_ERR_TX    = 5'h17,
      SBL_S_HALT      = 5'h16
   } sbl_state_type;

   // Only the initial rate code is known to be legal for this part
   function automatic logic sbl_baud_ok(input logic [7:0] code);
      return code == SBL_BAUD_9600;
   endfunction

   // Receive error byte: framing error wins over overrun
   function automatic logic [7:0] sbl_rx_err_code(input logic ferr);
      return ferr ? SBL_ERR_FRAME : SBL_ERR_OVRN;
   endfunction

endpackage

// >>> core/sbl_loader.sv
`timescale 1ns/1ns
module sbl_loader
   import sbl_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst,
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   input  wire logic        rx_ferr,
   input  wire logic        rx_oerr,
   input  wire logic        tx_ready,
   input  wire logic        read_protect,
   input  wire logic [7:0]  mem_rdata,
   output logic             tx_valid_q,
   output logic [7:0]       tx_byte_q,
   output logic             autobaud_q,
   output logic [7:0]       baud_code_q,
   output logic             baud_apply_q,
   output logic             mem_rd_q,
   output logic [15:0]      mem_addr_q,
   output logic             ram_we_q,
   output logic [15:0]      ram_addr_q,
   output logic [7:0]       ram_wdata_q,
   output logic             jump_q,
   output logic [15:0]      jump_addr_q,
   output logic             halt_q
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   sbl_state_type st_q, st_d;
   logic        tx_valid_d, autobaud_d, baud_apply_d, mem_rd_d, ram_we_d, jump_d, halt_d;
   logic [7:0]  tx_byte_d, baud_code_d, ram_wdata_d;
   logic [15:0] mem_addr_d, ram_addr_d, jump_addr_d;
   logic        rdv_q;
   logic [1:0]  err_cnt_q, err_cnt_d;
   logic [15:0] pca_q, pca_d, psa_q, psa_d;
   logic [7:0]  cnt_q, cnt_d, pw_n_q, pw_n_d, hold_q, hold_d;
   logic [7:0]  rec_len_q, rec_len_d, rsum_q, rsum_d;
   logic [15:0] rec_addr_q, rec_addr_d, sum_q, sum_d;
   logic        end_rec_q, end_rec_d, first_q, first_d;
   logic        tx_acc, rx_ok, rx_bad;

   assign tx_acc = tx_valid_q & tx_ready;
   assign rx_ok  = rx_valid & ~rx_ferr & ~rx_oerr;
   assign rx_bad = rx_valid & (rx_ferr | rx_oerr);

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      st_d         = st_q;
      tx_valid_d   = tx_valid_q & ~tx_ready;
      tx_byte_d    = tx_byte_q;
      autobaud_d   = 1'b0;
      baud_code_d  = baud_code_q;
      baud_apply_d = baud_apply_q;
      mem_rd_d     = 1'b0;
      mem_addr_d   = mem_addr_q;
      ram_we_d     = 1'b0;
      ram_addr_d   = ram_addr_q;
      ram_wdata_d  = ram_wdata_q;
      jump_d       = 1'b0;
      jump_addr_d  = jump_addr_q;
      halt_d       = halt_q;
      err_cnt_d    = err_cnt_q;
      pca_d        = pca_q;
      psa_d        = psa_q;
      cnt_d        = cnt_q;
      pw_n_d       = pw_n_q;
      hold_d       = hold_q;
      rec_len_d    = rec_len_q;
      rsum_d       = rsum_q;
      rec_addr_d   = rec_addr_q;
      sum_d        = sum_q;
      end_rec_d    = end_rec_q;
      first_d      = first_q;
      unique case (st_q)
         // RULE_01 match and echo
         SBL_S_MATCH: begin
            autobaud_d = 1'b1;
            if (rx_ok && rx_byte == SBL_MATCH) begin
               tx_valid_d = 1'b1;
               tx_byte_d  = SBL_MATCH;
               autobaud_d = 1'b0;
               st_d       = SBL_S_ECHO1;
            end
         end
         SBL_S_ECHO1: if (tx_acc) st_d = SBL_S_BAUD;
         // RULE_02 baud code check
         SBL_S_BAUD: if (rx_valid) begin
            err_cnt_d  = 2'h0;
            tx_valid_d = 1'b1;
            if (rx_bad) begin
               tx_byte_d = sbl_rx_err_code(rx_ferr);
               st_d      = SBL_S_ERR_TX;
            end else if (!sbl_baud_ok(rx_byte)) begin
               tx_byte_d = SBL_ERR_BAUD;
               st_d      = SBL_S_ERR_TX;
            end else begin
               tx_byte_d   = rx_byte;
               baud_code_d = rx_byte;
               st_d        = SBL_S_ECHO2;
            end
         end
         // RULE_03 new rate after echo
         SBL_S_ECHO2: if (tx_acc) begin
            baud_apply_d = 1'b1;
            st_d         = SBL_S_CMD;
         end
         // RULE_04 command check
         SBL_S_CMD: if (rx_valid) begin
            err_cnt_d  = 2'h0;
            tx_valid_d = 1'b1;
            if (rx_bad) begin
               tx_byte_d = sbl_rx_err_code(rx_ferr);
               st_d      = SBL_S_ERR_TX;
            end else if (rx_byte != SBL_CMD_RAM) begin
               tx_byte_d = SBL_ERR_CMD;
               st_d      = SBL_S_ERR_TX;
            end else begin
               tx_byte_d = rx_byte;
               st_d      = SBL_S_ECHO3;
            end
         end
         // RULE_11 read protection blocks loading
         SBL_S_ECHO3: if (tx_acc) st_d = read_protect ? SBL_S_HALT : SBL_S_PCA_H;
         // RULE_05 silent count address
         SBL_S_PCA_H: if (rx_valid) begin
            pca_d[15:8] = rx_byte;
            st_d        = rx_bad ? SBL_S_HALT : SBL_S_PCA_L;
         end
         SBL_S_PCA_L: if (rx_valid) begin
            pca_d[7:0] = rx_byte;
            st_d       = rx_bad ? SBL_S_HALT : SBL_S_PSA_H;
         end
         // RULE_06 silent start address
         SBL_S_PSA_H: if (rx_valid) begin
            psa_d[15:8] = rx_byte;
            st_d        = rx_bad ? SBL_S_HALT : SBL_S_PSA_L;
         end
         // RULE_10 receive error halts
         SBL_S_PSA_L: if (rx_valid) begin
            psa_d[7:0] = rx_byte;
            mem_addr_d = SBL_BLANK_LO;
            st_d       = rx_bad ? SBL_S_HALT : SBL_S_BLANK_RD;
         end
         SBL_S_BLANK_RD: begin
            mem_rd_d = 1'b1;
            st_d     = SBL_S_BLANK_CHK;
         end
         // RULE_08 blank part skips password
         SBL_S_BLANK_CHK: if (rdv_q) begin
            if (mem_rdata != SBL_BLANK_BYTE) begin
               st_d = SBL_S_CNT_RD;
            end else if (mem_addr_q == SBL_BLANK_HI) begin
               st_d = SBL_S_HEX_IDLE;
            end else begin
               mem_addr_d = mem_addr_q + 16'h0001;
               st_d       = SBL_S_BLANK_RD;
            end
         end
         SBL_S_CNT_RD: begin
            mem_rd_d   = 1'b1;
            mem_addr_d = pca_q;
            st_d       = SBL_S_CNT_CHK;
         end
         // RULE_20 password length fetch
         SBL_S_CNT_CHK: if (rdv_q) begin
            pw_n_d = mem_rdata;
            cnt_d  = 8'h00;
            st_d   = (mem_rdata == 8'h00) ? SBL_S_HEX_IDLE : SBL_S_PW_RX;
         end
         // RULE_07 silent password bytes
         SBL_S_PW_RX: if (rx_valid) begin
            hold_d     = rx_byte;
            mem_rd_d   = rx_ok;
            mem_addr_d = psa_q + {8'h00, cnt_q};
            st_d       = rx_bad ? SBL_S_HALT : SBL_S_PW_CHK;
         end
         // RULE_09 mismatch halts
         SBL_S_PW_CHK: if (rdv_q) begin
            cnt_d = cnt_q + SBL_ONE8;
            if (mem_rdata != hold_q) st_d = SBL_S_HALT;
            else if (cnt_q + SBL_ONE8 == pw_n_q) st_d = SBL_S_HEX_IDLE;
            else st_d = SBL_S_PW_RX;
         end
         // RULE_13 discard until start mark
         SBL_S_HEX_IDLE: if (rx_valid) begin
            if (rx_bad) st_d = SBL_S_HALT;
            else if (rx_byte == SBL_REC_START) st_d = SBL_S_HEX_LEN;
         end
         // RULE_15 receive error halts silently
         SBL_S_HEX_LEN: if (rx_valid) begin
            rec_len_d = rx_byte;
            rsum_d    = rx_byte;
            st_d      = rx_bad ? SBL_S_HALT : SBL_S_HEX_AH;
         end
         SBL_S_HEX_AH: if (rx_valid) begin
            rec_addr_d[15:8] = rx_byte;
            rsum_d           = rsum_q + rx_byte;
            st_d             = rx_bad ? SBL_S_HALT : SBL_S_HEX_AL;
         end
         SBL_S_HEX_AL: if (rx_valid) begin
            rec_addr_d[7:0] = rx_byte;
            rsum_d          = rsum_q + rx_byte;
            st_d            = rx_bad ? SBL_S_HALT : SBL_S_HEX_TYPE;
         end
         // RULE_15 unknown record type halts
         SBL_S_HEX_TYPE: if (rx_valid) begin
            rsum_d    = rsum_q + rx_byte;
            cnt_d     = 8'h00;
            end_rec_d = rx_byte == SBL_REC_END;
            if (rx_bad || (rx_byte != SBL_REC_DATA && rx_byte != SBL_REC_END))
               st_d = SBL_S_HALT;
            else if (rec_len_q == 8'h00) st_d = SBL_S_HEX_CK;
            else st_d = SBL_S_HEX_DATA;
         end
         // RULE_14 data bytes into RAM
         SBL_S_HEX_DATA: if (rx_valid) begin
            rsum_d      = rsum_q + rx_byte;
            ram_we_d    = rx_ok;
            ram_addr_d  = rec_addr_q + {8'h00, cnt_q};
            ram_wdata_d = rx_byte;
            sum_d       = sum_q + {8'h00, rx_byte};
            cnt_d       = cnt_q + SBL_ONE8;
            if (rx_bad) st_d = SBL_S_HALT;
            else if (cnt_q + SBL_ONE8 == rec_len_q) st_d = SBL_S_HEX_CK;
         end
         // RULE_16 checksum upper byte first
         SBL_S_HEX_CK: if (rx_valid) begin
            if (rx_bad || rsum_q + rx_byte != 8'h00) begin
               st_d = SBL_S_HALT;
            end else if (end_rec_q) begin
               tx_valid_d = 1'b1;
               tx_byte_d  = sum_q[15:8];
               st_d       = SBL_S_SUM_H;
            end else begin
               // RULE_18 first data record sets entry
               if (!first_q) jump_addr_d = rec_addr_q;
               first_d = 1'b1;
               st_d    = SBL_S_HEX_IDLE;
            end
         end
         SBL_S_SUM_H: if (tx_acc) begin
            tx_valid_d = 1'b1;
            tx_byte_d  = sum_q[7:0];
            st_d       = SBL_S_SUM_L;
         end
         // RULE_18 jump after lower byte
         SBL_S_SUM_L: if (tx_acc) begin
            jump_d = 1'b1;
            st_d   = SBL_S_RUN;
         end
         SBL_S_RUN: st_d = SBL_S_RUN;
         // RULE_02 three error copies
         SBL_S_ERR_TX: if (tx_acc) begin
            err_cnt_d = err_cnt_q + SBL_ONE2;
            if (err_cnt_q + SBL_ONE2 == SBL_ERR_REPEAT) st_d = SBL_S_HALT;
            else tx_valid_d = 1'b1;
         end
         // RULE_21 halted until reset
         SBL_S_HALT: begin
            halt_d     = 1'b1;
            tx_valid_d = 1'b0;
         end
         default: st_d = SBL_S_HALT;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         st_q <= SBL_S_MATCH;
         tx_valid_q <= 1'b0;
         tx_byte_q <= 8'h00;
         autobaud_q <= 1'b0;
         baud_code_q <= SBL_BAUD_9600;
         baud_apply_q <= 1'b0;
         mem_rd_q <= 1'b0;
         mem_addr_q <= 16'h0000;
         rdv_q <= 1'b0;
         ram_we_q <= 1'b0;
         ram_addr_q <= 16'h0000;
         ram_wdata_q <= 8'h00;
         jump_q <= 1'b0;
         jump_addr_q <= 16'h0000;
         halt_q <= 1'b0;
         err_cnt_q <= 2'h0;
         pca_q <= 16'h0000;
         psa_q <= 16'h0000;
         cnt_q <= 8'h00;
         pw_n_q <= 8'h00;
         hold_q <= 8'h00;
         rec_len_q <= 8'h00;
         rsum_q <= 8'h00;
         rec_addr_q <= 16'h0000;
         sum_q <= 16'h0000;
         end_rec_q <= 1'b0;
         first_q <= 1'b0;
      end else begin
         st_q <= st_d;
         tx_valid_q <= tx_valid_d;
         tx_byte_q <= tx_byte_d;
         autobaud_q <= autobaud_d;
         baud_code_q <= baud_code_d;
         baud_apply_q <= baud_apply_d;
         mem_rd_q <= mem_rd_d;
         mem_addr_q <= mem_addr_d;
         rdv_q <= mem_rd_q;
         ram_we_q <= ram_we_d;
         ram_addr_q <= ram_addr_d;
         ram_wdata_q <= ram_wdata_d;
         jump_q <= jump_d;
         jump_addr_q <= jump_addr_d;
         halt_q <= halt_d;
         err_cnt_q <= err_cnt_d;
         pca_q <= pca_d;
         psa_q <= psa_d;
         cnt_q <= cnt_d;
         pw_n_q <= pw_n_d;
         hold_q <= hold_d;
         rec_len_q <= rec_len_d;
         rsum_q <= rsum_d;
         rec_addr_q <= rec_addr_d;
         sum_q <= sum_d;
         end_rec_q <= end_rec_d;
         first_q <= first_d;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   match_echo_a: assert property ( // RULE_01
      st_q == SBL_S_MATCH && rx_ok && rx_byte == SBL_MATCH |=> tx_valid_q && tx_byte_q == SBL_MATCH)
      else $error("match byte not echoed");
   nomatch_quiet_a: assert property ( // RULE_01
      st_q == SBL_S_MATCH && rx_valid && rx_byte != SBL_MATCH |=> !tx_valid_q && st_q == SBL_S_MATCH)
      else $error("unmatched byte answered");
   err_code_a: assert property ( // RULE_02
      st_q == SBL_S_BAUD && rx_ok && !sbl_baud_ok(rx_byte)
      |=> (tx_valid_q && tx_byte_q == SBL_ERR_BAUD) [*3])
      else $error("baud error code wrong");
   baud_switch_a: assert property ( // RULE_03
      $rose(baud_apply_q) |-> $past(st_q) == SBL_S_ECHO2 && $past(tx_acc))
      else $error("rate switched at wrong time");
   cmd_error_a: assert property ( // RULE_04
      st_q == SBL_S_CMD && rx_ok && rx_byte != SBL_CMD_RAM |=> tx_byte_q == SBL_ERR_CMD)
      else $error("command error code wrong");
   loader_quiet_a: assert property ( // RULE_13
      st_q inside {SBL_S_PCA_H, SBL_S_PSA_L, SBL_S_PW_RX, SBL_S_HEX_IDLE, SBL_S_HEX_DATA}
      |-> !tx_valid_q)
      else $error("byte sent during silent phase");
   pw_mismatch_a: assert property ( // RULE_09
      st_q == SBL_S_PW_CHK && rdv_q && mem_rdata != hold_q |=> ##1 halt_q)
      else $error("password mismatch did not halt");
   ram_write_a: assert property ( // RULE_14
      ram_we_q |-> $past(st_q) == SBL_S_HEX_DATA && ram_wdata_q == $past(rx_byte))
      else $error("RAM write outside data record");
   sum_order_a: assert property ( // RULE_16
      st_q == SBL_S_SUM_H && tx_valid_q |-> tx_byte_q == sum_q[15:8])
      else $error("checksum upper byte wrong");
   jump_after_a: assert property ( // RULE_18
      jump_q |-> $past(st_q) == SBL_S_SUM_L && $past(tx_acc) && st_q == SBL_S_RUN)
      else $error("jump not after checksum");
   halt_stays_a: assert property ( // RULE_21
      halt_q |=> halt_q && !tx_valid_q && !ram_we_q && !jump_q)
      else $error("halt left or output active");

endmodule // sbl_loader

// >>> tb/sbl_host.sv
`timescale 1ns/1ns
module sbl_host (
   input  wire logic        mclk,
   input  wire logic        mem_rd_q,
   input  wire logic [15:0] mem_addr_q,
   output logic             tx_ready,
   output logic [7:0]       mem_rdata
);
   // Unwritten places read as erased
   logic [7:0] mem [0:65535];
   logic       hold;

   initial begin
      tx_ready  = 1'b0;
      mem_rdata = 8'h00;
      hold      = 1'b0;
      for (int i = 0; i < 65536; i++) mem[i] = 8'hFF;
   end

   // ----------------------------------------
   // Boot memory and transmitter
   // ----------------------------------------
   // Data stays two cycles, then toggles so stale data never looks like an answer
   always @(posedge mclk) begin
      hold <= mem_rd_q;
      if (mem_rd_q) begin
         mem_rdata <= mem[mem_addr_q];
      end else if (!hold) begin
         mem_rdata <= ~mem_rdata;
      end
      tx_ready <= ($urandom % 3) != 0;
   end
endmodule // sbl_host

// >>> tb/tb_sbl_loader.sv
`timescale 1ns/1ns
module tb_sbl_loader;
   import sbl_pkg::*;
   localparam int GAP   = 200;
   localparam int LIMIT = 90000;
   logic        mclk = 1'b0;
   logic        rst = 1'b1;
   logic        rx_valid = 1'b0;
   logic [7:0]  rx_byte = 8'h00;
   logic        rx_ferr = 1'b0;
   logic        rx_oerr = 1'b0;
   logic        read_protect = 1'b0;
   logic        tx_ready, tx_valid_q, autobaud_q, baud_apply_q, mem_rd_q, ram_we_q;
   logic        jump_q, halt_q;
   logic [7:0]  mem_rdata, tx_byte_q, baud_code_q, ram_wdata_q;
   logic [15:0] mem_addr_q, ram_addr_q, jump_addr_q;
   logic [7:0]  exp_tx[$];
   logic [23:0] exp_wr[$];
   logic [15:0] exp_jmp[$];
   int          sum, first, cyc, err_total, total_checks;

   always #4 mclk = ~mclk;

   sbl_loader i_sbl_loader (.mclk(mclk), .rst(rst), .rx_valid(rx_valid), .rx_byte(rx_byte),
      .rx_ferr(rx_ferr), .rx_oerr(rx_oerr), .tx_ready(tx_ready), .read_protect(read_protect),
      .mem_rdata(mem_rdata), .tx_valid_q(tx_valid_q), .tx_byte_q(tx_byte_q),
      .autobaud_q(autobaud_q), .baud_code_q(baud_code_q), .baud_apply_q(baud_apply_q),
      .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .ram_we_q(ram_we_q),
      .ram_addr_q(ram_addr_q), .ram_wdata_q(ram_wdata_q), .jump_q(jump_q),
      .jump_addr_q(jump_addr_q), .halt_q(halt_q));

   sbl_host i_sbl_host (.mclk(mclk), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q),
      .tx_ready(tx_ready), .mem_rdata(mem_rdata));

   // ----------------------------------------
   // Comparison and reporting
   // ----------------------------------------
   task automatic note(input bit bad, input string what);
      total_checks++;
      if (bad) begin
         err_total++;
         $display("ERROR %0t %s", $time, what);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      note(got !== exp, $sformatf("flag %b expected %b", got, exp));
   endtask
   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      note(got !== exp, $sformatf("sent %h expected %h", got, exp));
   endtask
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      note(got !== exp, $sformatf("value %h expected %h", got, exp));
   endtask
   task automatic chkw(input logic [23:0] got, input logic [23:0] exp);
      note(got !== exp, $sformatf("ram write %h expected %h", got, exp));
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Every result is matched against the model queues as it appears
   always @(posedge mclk) begin
      if (!rst && tx_valid_q && tx_ready) begin
         if (exp_tx.size() > 0) chk8(tx_byte_q, exp_tx.pop_front());
         else chk8(tx_byte_q, ~tx_byte_q);
      end
      if (!rst && ram_we_q) begin
         if (exp_wr.size() > 0) chkw({ram_addr_q, ram_wdata_q}, exp_wr.pop_front());
         else chkw({ram_addr_q, ram_wdata_q}, ~{ram_addr_q, ram_wdata_q});
      end
      if (!rst && jump_q) begin
         chk16(16'(exp_tx.size()), 16'h0000);
         if (exp_jmp.size() > 0) chk16(jump_addr_q, exp_jmp.pop_front());
         else chk16(jump_addr_q, ~jump_addr_q);
      end
      // Timeout last, so nothing runs after the verdict
      cyc++;
      if (cyc == LIMIT) begin
         err_total++;
         print_verdict();
      end
   end

   // ----------------------------------------
   // Controller side stimulus
   // ----------------------------------------
   task automatic restart;
      rst <= 1'b1;
      repeat (8) @(posedge mclk);
      exp_tx.delete();
      exp_wr.delete();
      exp_jmp.delete();
      sum = 0;
      first = -1;
      rst <= 1'b0;
   endtask
   // Gap stands in for the slow UART byte time and covers the memory scans
   task automatic send(input logic [7:0] b, input logic fe = 1'b0, input logic oe = 1'b0);
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_byte <= b;
      rx_ferr <= fe;
      rx_oerr <= oe;
      @(posedge mclk);
      rx_valid <= 1'b0;
      repeat (GAP) @(posedge mclk);
      #1;
   endtask
   task automatic settle(input logic h);
      repeat (GAP) @(posedge mclk);
      #1;
      chk1(halt_q, h);
      chk16(16'(exp_tx.size() + exp_wr.size() + exp_jmp.size()), 16'h0000);
      // Return on an edge so following drives land at a rising edge
      @(posedge mclk);
   endtask
   task automatic head(input logic [7:0] cmd);
      @(posedge mclk);
      #1;
      chk1(autobaud_q, 1'b1);
      send(8'h11);
      exp_tx.push_back(SBL_MATCH);
      send(SBL_MATCH);
      exp_tx.push_back(SBL_BAUD_9600);
      send(SBL_BAUD_9600);
      chk1(baud_apply_q, 1'b1);
      chk8(baud_code_q, SBL_BAUD_9600);
      exp_tx.push_back(cmd);
      send(cmd);
   endtask
   task automatic addrs(input logic [15:0] pca, input logic [15:0] psa);
      send(pca[15:8]);
      send(pca[7:0]);
      send(psa[15:8]);
      send(psa[7:0]);
   endtask
   task automatic rec(input int len, input logic [15:0] a, input logic [7:0] typ,
                      input logic bad);
      logic [7:0] d;
      logic [7:0] ck;
      ck = 8'(len) + a[15:8] + a[7:0] + typ;
      send(SBL_REC_START);
      send(8'(len));
      send(a[15:8]);
      send(a[7:0]);
      send(typ);
      for (int i = 0; i < len; i++) begin
         d = 8'($urandom);
         ck += d;
         sum += int'(d);
         if (first < 0) first = int'(a);
         exp_wr.push_back({a + 16'(i), d});
         send(d);
      end
      if (typ == SBL_REC_END && !bad) begin
         exp_tx.push_back(8'(sum >> 8));
         exp_tx.push_back(8'(sum));
         exp_jmp.push_back(16'(first));
      end
      // A bad checksum is always one off, never zero by chance
      send(bad ? 8'h01 - ck : 8'h00 - ck);
   endtask
   task automatic errcase(input int k);
      logic [7:0] b;
      logic [7:0] code;
      b = (k == 0) ? 8'h29 : (k == 1) ? SBL_BAUD_9600 : (k == 2) ? SBL_CMD_RAM : 8'h77;
      code = (k == 0) ? SBL_ERR_BAUD : (k == 1) ? SBL_ERR_FRAME :
             (k == 2) ? SBL_ERR_OVRN : SBL_ERR_CMD;
      restart();
      exp_tx.push_back(SBL_MATCH);
      send(SBL_MATCH);
      if (k >= 2) begin
         exp_tx.push_back(SBL_BAUD_9600);
         send(SBL_BAUD_9600);
      end
      repeat (3) exp_tx.push_back(code);
      send(b, k == 1, k == 2);
      settle(1'b1);
   endtask

   initial begin
      void'($urandom(32'hED197A5E));
      // Blank part: junk before the start mark, two data records, end record
      restart();
      head(SBL_CMD_RAM);
      addrs(16'h1234, 16'h5678);
      send(8'h00);
      send(8'h55);
      rec(3, 16'h0100, SBL_REC_DATA, 1'b0);
      rec(2, 16'h0200, SBL_REC_DATA, 1'b0);
      rec(0, 16'h0000, SBL_REC_END, 1'b0);
      settle(1'b0);
      // Protected part: right password, then a wrong one
      i_sbl_host.mem[16'hFFE0] = 8'h00;
      i_sbl_host.mem[16'h4000] = 8'h02;
      i_sbl_host.mem[16'h5000] = 8'hA5;
      i_sbl_host.mem[16'h5001] = 8'h3C;
      for (int k = 0; k < 2; k++) begin
         restart();
         head(SBL_CMD_RAM);
         addrs(16'h4000, 16'h5000);
         send(8'hA5);
         send(k == 1 ? 8'h3D : 8'h3C);
         if (k == 0) begin
            rec(1, 16'h0300, SBL_REC_DATA, 1'b0);
            rec(0, 16'h0000, SBL_REC_END, 1'b0);
         end
         settle(k == 1);
      end
      send(SBL_MATCH);
      settle(1'b1);
      // Receive error inside a password address
      restart();
      head(SBL_CMD_RAM);
      send(8'h40, 1'b1);
      settle(1'b1);
      // Read protection stops the loader after the command echo
      read_protect <= 1'b1;
      restart();
      head(SBL_CMD_RAM);
      addrs(16'h4000, 16'h5000);
      settle(1'b1);
      read_protect <= 1'b0;
      // Echo stage errors, every error code
      for (int k = 0; k < 4; k++) errcase(k);
      // Bad record checksum, then an unknown record type, halt silently on a blank part
      i_sbl_host.mem[16'hFFE0] = 8'hFF;
      for (int k = 0; k < 2; k++) begin
         restart();
         head(SBL_CMD_RAM);
         addrs(16'h1234, 16'h5678);
         rec(2 - 2 * k, 16'h0400, k == 0 ? SBL_REC_DATA : 8'h02, k == 0);
         rec(0, 16'h0000, SBL_REC_END, 1'b1);
         settle(1'b1);
      end
      print_verdict();
   end
endmodule // tb_sbl_loader
